// ### cssd_clock_control.sv
// clock source control, divider settings, flash clock enable and main oscillator stop detector
`default_nettype none
// How it works
// - each of the five oscillators has its own start and stop bit
// - flash clock paces flash program, erase and data flash reads
// - instruction fetch and RAM access always take one cycle
// - a stopped main oscillator is detected and, with main selected, the core falls back to slow oscillator
// - detector is off after reset and runs only once software enables it
// - main selected and stop seen: run on slow oscillator, select field untouched
// - fallback holds until flag cleared; select slow, clear flag, reselect main
// - multiplier loop selected at stop: source and field unchanged, loop runs free
// - a detected stop raises the non-maskable interrupt only when its enable is set
// - the watchdog oscillator keeps its on/off state unchanged after a stop event
// - after reset: slow oscillator selected, main oscillator and multiplier loop off
module cssd_clock_control
    import cssd_pkg::*;
#(
    parameter int STOP_CYC = STOP_DET_CYC,
    parameter bit RST_FAST_STOP = 1'b1,
    parameter bit RST_WDOG_STOP = 1'b1
) (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic we_i,
    input wire logic re_i,
    output logic [DATA_W-1:0] rdata_o,
    input wire logic main_osc_tick_i,
    output logic main_osc_en_o,
    output logic sub_osc_en_o,
    output logic fast_osc_en_o,
    output logic slow_osc_en_o,
    output logic watchdog_osc_en_o,
    output logic pll_en_o,
    output logic [2:0] sys_clk_source_o,
    output logic pll_free_run_o,
    output logic [DIV_W-1:0] core_div_o,
    output logic [DIV_W-1:0] flash_div_o,
    output logic [DIV_W-1:0] periph_gen_div_o,
    output logic [DIV_W-1:0] periph_conv_div_o,
    output logic flash_clk_tick_o,
    output logic mem_wait_o,
    output logic stop_detect_nmi_o
);
    // ===================================================
    // elaboration checks
    // stall counter is 16 bits; a one-cycle window cannot tell a slow tick from a stopped one
    if (STOP_CYC < 2 || STOP_CYC > 65535) begin : g_bad_stop_cyc
        $error("STOP_CYC out of range");
    end

    // ===================================================
    // state
    typedef struct packed {
        logic main_stop;
        logic sub_stop;
        logic fast_stop;
        logic slow_stop;
        logic wdog_stop;
        logic pll_stop;
        logic [2:0] clock_source_field;
        logic [DIV_W-1:0] core_div;
        logic [DIV_W-1:0] flash_div;
        logic [DIV_W-1:0] pgen_div;
        logic [DIV_W-1:0] pconv_div;
        logic det_en;
        logic flag;
        logic forced;
        logic nmi_en;
        logic tick_prev;
        logic [15:0] stall_cnt;
        logic main_dead;
        logic [FCNT_W-1:0] fcnt;
        logic ftick;
        logic [2:0] src;
        logic pll_free;
        logic nmi;
        logic [DATA_W-1:0] rdata;
    } cssd_state_s;

    cssd_state_s s_q;
    cssd_state_s s_d;
    logic detect;
    logic flag_clr;
    logic [FCNT_W-1:0] fmask;
    logic [DATA_W-1:0] rd_mux;

    // ===================================================
    // next state
    always_comb begin
        s_d = s_q;
        // oscillator on/off bits, one per source
        if (we_i) begin
            unique case (addr_i)
                OFS_MAIN_OSC_CTL: s_d.main_stop = wdata_i[BIT_STOP];
                OFS_SUB_OSC_CTL: s_d.sub_stop = wdata_i[BIT_STOP];
                OFS_FAST_OSC_CTL: s_d.fast_stop = wdata_i[BIT_STOP];
                OFS_SLOW_OSC_CTL: s_d.slow_stop = wdata_i[BIT_STOP];
                OFS_WDOG_OSC_CTL: s_d.wdog_stop = wdata_i[BIT_STOP];
                OFS_PLL_CTL: s_d.pll_stop = wdata_i[BIT_STOP];
                OFS_SRC_SEL: s_d.clock_source_field = wdata_i[SRC_LSB +: 3];
                OFS_DIV_CORE_FLASH: begin
                    s_d.core_div = wdata_i[DIV_LO_LSB +: DIV_W];
                    s_d.flash_div = wdata_i[DIV_HI_LSB +: DIV_W];
                end
                OFS_DIV_PERIPH: begin
                    s_d.pgen_div = wdata_i[DIV_LO_LSB +: DIV_W];
                    s_d.pconv_div = wdata_i[DIV_HI_LSB +: DIV_W];
                end
                OFS_DET_CTL: s_d.det_en = wdata_i[BIT_DET_EN];
                OFS_NMI_EN: s_d.nmi_en = wdata_i[BIT_NMI_EN];
                default: ;
            endcase
        end
        // divider codes above the largest ratio saturate
        if (s_d.flash_div > DIV_MAX) s_d.flash_div = DIV_MAX;
        if (s_d.core_div > DIV_MAX) s_d.core_div = DIV_MAX;
        if (s_d.pgen_div > DIV_MAX) s_d.pgen_div = DIV_MAX;
        if (s_d.pconv_div > DIV_MAX) s_d.pconv_div = DIV_MAX;

        // stop detector: no edge on the main oscillator tick for STOP_CYC cycles
        s_d.tick_prev = main_osc_tick_i;
        if (main_osc_tick_i != s_q.tick_prev || !s_q.det_en) begin
            s_d.stall_cnt = 16'h0000;
            s_d.main_dead = 1'b0;
        end else if (s_q.stall_cnt >= 16'(STOP_CYC - 1)) begin
            s_d.main_dead = 1'b1;
        end else begin
            s_d.stall_cnt = s_q.stall_cnt + 16'h0001;
        end

        // flag clear is refused while main is still selected, so the core never leaves
        // the fallback for a dead oscillator
        flag_clr = we_i && addr_i == OFS_DET_STATUS && !wdata_i[BIT_FLAG] && s_q.clock_source_field != SRC_MAIN;
        detect = s_q.det_en && s_q.main_dead;
        if (flag_clr) begin
            s_d.flag = 1'b0;
            s_d.forced = 1'b0;
        end
        // set wins over a clear in the same cycle
        if (detect) begin
            s_d.flag = 1'b1;
            if (s_q.clock_source_field == SRC_MAIN || s_q.forced) s_d.forced = 1'b1;
        end

        // effective source: select field is never rewritten by the detector
        if (s_q.forced) begin
            s_d.src = SRC_SLOW_INT;
        end else begin
            s_d.src = s_q.clock_source_field;
        end
        s_d.pll_free = s_q.flag && s_q.clock_source_field == SRC_PLL && !s_q.forced;
        s_d.nmi = s_q.flag && s_q.nmi_en;

        // flash clock enable: one pulse every 2^div cycles
        fmask = FCNT_W'((7'h01 << s_q.flash_div) - 7'h01);
        s_d.ftick = s_q.fcnt == '0;
        if (s_q.fcnt >= fmask) begin
            s_d.fcnt = '0;
        end else begin
            s_d.fcnt = s_q.fcnt + FCNT_W'(1);
        end

        // register read, data stand only in the following cycle
        rd_mux = '0;
        unique case (addr_i)
            OFS_MAIN_OSC_CTL: rd_mux[BIT_STOP] = s_q.main_stop;
            OFS_SUB_OSC_CTL: rd_mux[BIT_STOP] = s_q.sub_stop;
            OFS_FAST_OSC_CTL: rd_mux[BIT_STOP] = s_q.fast_stop;
            OFS_SLOW_OSC_CTL: rd_mux[BIT_STOP] = s_q.slow_stop;
            OFS_WDOG_OSC_CTL: rd_mux[BIT_STOP] = s_q.wdog_stop;
            OFS_PLL_CTL: rd_mux[BIT_STOP] = s_q.pll_stop;
            OFS_SRC_SEL: rd_mux[SRC_LSB +: 3] = s_q.clock_source_field;
            OFS_DIV_CORE_FLASH: rd_mux = {s_q.flash_div, s_q.core_div};
            OFS_DIV_PERIPH: rd_mux = {s_q.pconv_div, s_q.pgen_div};
            OFS_DET_CTL: rd_mux[BIT_DET_EN] = s_q.det_en;
            OFS_DET_STATUS: begin
                rd_mux[BIT_FLAG] = s_q.flag;
                rd_mux[BIT_MAIN_DEAD] = s_q.main_dead;
                rd_mux[BIT_FORCED] = s_q.forced;
            end
            OFS_NMI_EN: rd_mux[BIT_NMI_EN] = s_q.nmi_en;
            OFS_CLK_STATUS: begin
                rd_mux[SRC_LSB +: 3] = s_q.src;
                rd_mux[BIT_PLL_FREE] = s_q.pll_free;
            end
            default: rd_mux = '0;
        endcase
        s_d.rdata = re_i ? rd_mux : '0;
    end

    // ===================================================
    // registers
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_q <= '0;
            s_q.main_stop <= RST_MAIN_STOP;
            s_q.sub_stop <= RST_SUB_STOP;
            s_q.fast_stop <= RST_FAST_STOP;
            s_q.slow_stop <= RST_SLOW_STOP;
            s_q.wdog_stop <= RST_WDOG_STOP;
            s_q.pll_stop <= RST_PLL_STOP;
            s_q.clock_source_field <= SRC_SLOW_INT;
            s_q.src <= SRC_SLOW_INT;
            s_q.core_div <= RST_DIV;
            s_q.flash_div <= RST_DIV;
            s_q.pgen_div <= RST_DIV;
            s_q.pconv_div <= RST_DIV;
        end else begin
            s_q <= s_d;
        end
    end

    // ===================================================
    // outputs, all straight from state except mem_wait_o, tied low
    assign rdata_o = s_q.rdata;
    assign main_osc_en_o = !s_q.main_stop;
    assign sub_osc_en_o = !s_q.sub_stop;
    assign fast_osc_en_o = !s_q.fast_stop;
    assign slow_osc_en_o = !s_q.slow_stop;
    assign watchdog_osc_en_o = !s_q.wdog_stop;
    assign pll_en_o = !s_q.pll_stop;
    assign sys_clk_source_o = s_q.src;
    assign pll_free_run_o = s_q.pll_free;
    assign core_div_o = s_q.core_div;
    assign flash_div_o = s_q.flash_div;
    assign periph_gen_div_o = s_q.pgen_div;
    assign periph_conv_div_o = s_q.pconv_div;
    assign flash_clk_tick_o = s_q.ftick;
    // fetch and RAM never wait on the flash clock, so this stays low
    assign mem_wait_o = 1'b0;
    assign stop_detect_nmi_o = s_q.nmi;

    // ===================================================
    // assertions
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);

    property p_osc_ctl;
        we_i && addr_i == OFS_MAIN_OSC_CTL |=> main_osc_en_o == !$past(wdata_i[BIT_STOP]);
    endproperty
    a_osc_ctl: assert property (p_osc_ctl) else $error("main oscillator control not applied");

    property p_flash_tick_full;
        s_q.flash_div == '0 && $stable(s_q.flash_div) |=> flash_clk_tick_o;
    endproperty
    a_flash_tick_full: assert property (p_flash_tick_full) else $error("flash tick missing");

    property p_no_wait;
        (re_i || we_i) |-> ##1 !mem_wait_o ##1 !mem_wait_o;
    endproperty
    a_no_wait: assert property (p_no_wait) else $error("memory wait raised");

    property p_detect;
        s_q.det_en && s_q.main_dead |=> s_q.flag;
    endproperty
    a_detect: assert property (p_detect) else $error("stop not flagged");

    property p_needs_en;
        $rose(s_q.flag) |-> $past(s_q.det_en);
    endproperty
    a_needs_en: assert property (p_needs_en) else $error("flag set while detector off");

    property p_fallback;
        $rose(s_q.forced) |-> ##1 sys_clk_source_o == SRC_SLOW_INT && s_q.clock_source_field == $past(s_q.clock_source_field, 2);
    endproperty
    a_fallback: assert property (p_fallback) else $error("no fallback or select altered");

    property p_hold;
        $fell(s_q.flag) |-> $past(s_q.clock_source_field) != SRC_MAIN;
    endproperty
    a_hold: assert property (p_hold) else $error("flag cleared with main selected");

    property p_pll_free;
        s_q.flag && !s_q.forced && s_q.clock_source_field == SRC_PLL |=> sys_clk_source_o == SRC_PLL && pll_free_run_o;
    endproperty
    a_pll_free: assert property (p_pll_free) else $error("multiplier loop source changed");

    property p_nmi;
        ##1 stop_detect_nmi_o == $past(s_q.flag && s_q.nmi_en);
    endproperty
    a_nmi: assert property (p_nmi) else $error("interrupt not gated by enable");

    property p_wdog;
        $rose(s_q.flag) && !$past(we_i) |-> $stable(watchdog_osc_en_o);
    endproperty
    a_wdog: assert property (p_wdog) else $error("watchdog oscillator disturbed");

    property p_sticky;
        s_q.flag && !(we_i && addr_i == OFS_DET_STATUS) |=> s_q.flag && $stable(s_q.forced);
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag lost without a clear");

    property p_det_off;
        !s_q.det_en |=> !s_q.main_dead && s_q.stall_cnt == 16'h0000;
    endproperty
    a_det_off: assert property (p_det_off) else $error("detector counting while off");

    property p_fallback_hold;
        s_q.forced |=> sys_clk_source_o == SRC_SLOW_INT;
    endproperty
    a_fallback_hold: assert property (p_fallback_hold) else $error("fallback left early");

    property p_src_follows;
        !s_q.forced |=> sys_clk_source_o == $past(s_q.clock_source_field);
    endproperty
    a_src_follows: assert property (p_src_follows) else $error("source differs from select");

    property p_nmi_masked;
        !s_q.nmi_en |=> !stop_detect_nmi_o;
    endproperty
    a_nmi_masked: assert property (p_nmi_masked) else $error("interrupt raised while masked");

    property p_flash_half;
        flash_clk_tick_o && s_q.flash_div == 4'h1 && $stable(s_q.flash_div) |=> !flash_clk_tick_o ##1 flash_clk_tick_o;
    endproperty
    a_flash_half: assert property (p_flash_half) else $error("flash tick not every second cycle");

    property p_div_sat;
        core_div_o <= DIV_MAX && flash_div_o <= DIV_MAX && periph_gen_div_o <= DIV_MAX && periph_conv_div_o <= DIV_MAX;
    endproperty
    a_div_sat: assert property (p_div_sat) else $error("divider beyond largest ratio");

    // watchdog oscillator answers only its own control bit, never the detector
    property p_wdog_steady;
        !(we_i && addr_i == OFS_WDOG_OSC_CTL) |=> $stable(watchdog_osc_en_o);
    endproperty
    a_wdog_steady: assert property (p_wdog_steady) else $error("watchdog oscillator changed");

    c_fallback: cover property ($rose(s_q.forced));
    c_pll_free: cover property ($rose(pll_free_run_o));
    c_clear: cover property ($fell(s_q.flag));
    c_nmi: cover property ($rose(stop_detect_nmi_o));
endmodule
`default_nettype wire

// ### cssd_pkg.sv
// constants for the clock source control and main oscillator stop detector
`default_nettype none
package cssd_pkg;
    // ===================================================
    // timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int STOP_DET_TIME_NS = 2000;
    localparam int STOP_DET_CYC = (STOP_DET_TIME_NS / CLK_PERIOD_NS < 1) ? 1 : STOP_DET_TIME_NS / CLK_PERIOD_NS;
    // ===================================================
    // bus geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int DIV_W = 4;
    localparam int FCNT_W = 6;
    localparam logic [DIV_W-1:0] DIV_MAX = 4'h6;
    // ===================================================
    // register word offsets
    localparam logic [ADDR_W-1:0] OFS_MAIN_OSC_CTL = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_SUB_OSC_CTL = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_FAST_OSC_CTL = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_SLOW_OSC_CTL = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_WDOG_OSC_CTL = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_PLL_CTL = 4'h5;
    localparam logic [ADDR_W-1:0] OFS_SRC_SEL = 4'h6;
    localparam logic [ADDR_W-1:0] OFS_DIV_CORE_FLASH = 4'h7;
    localparam logic [ADDR_W-1:0] OFS_DIV_PERIPH = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_DET_CTL = 4'h9;
    localparam logic [ADDR_W-1:0] OFS_DET_STATUS = 4'hA;
    localparam logic [ADDR_W-1:0] OFS_NMI_EN = 4'hB;
    localparam logic [ADDR_W-1:0] OFS_CLK_STATUS = 4'hC;
    // ===================================================
    // field positions
    localparam int BIT_STOP = 0;
    localparam int BIT_DET_EN = 0;
    localparam int BIT_FLAG = 0;
    localparam int BIT_MAIN_DEAD = 1;
    localparam int BIT_FORCED = 2;
    localparam int BIT_NMI_EN = 0;
    localparam int BIT_PLL_FREE = 3;
    localparam int SRC_LSB = 0;
    localparam int DIV_LO_LSB = 0;
    localparam int DIV_HI_LSB = 4;
    // ===================================================
    // clock source field encoding
    localparam logic [2:0] SRC_SLOW_INT = 3'h0;
    localparam logic [2:0] SRC_FAST_INT = 3'h1;
    localparam logic [2:0] SRC_MAIN = 3'h2;
    localparam logic [2:0] SRC_SUB = 3'h3;
    localparam logic [2:0] SRC_PLL = 3'h4;
    // ===================================================
    // reset values
    localparam logic RST_MAIN_STOP = 1'b1;
    localparam logic RST_SUB_STOP = 1'b1;
    localparam logic RST_SLOW_STOP = 1'b0;
    localparam logic RST_PLL_STOP = 1'b1;
    localparam logic [DIV_W-1:0] RST_DIV = 4'h0;
endpackage
`default_nettype wire

// ### cssd_tb.sv
// self-checking testbench for the clock source control and stop detector
`default_nettype none
module tb
    import cssd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ==============================================
    // signals
    localparam int STOP_N = 4; // short window keeps the run brief
    localparam int LIMIT = 20000;
    logic sys_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [ADDR_W-1:0] addr_i = 4'h0;
    logic [DATA_W-1:0] wdata_i = 8'h00;
    logic we_i = 1'b0;
    logic re_i = 1'b0;
    logic main_osc_tick_i = 1'b0;
    logic [DATA_W-1:0] rdata_o;
    logic main_osc_en_o, sub_osc_en_o, fast_osc_en_o, slow_osc_en_o, watchdog_osc_en_o, pll_en_o;
    logic [2:0] sys_clk_source_o;
    logic pll_free_run_o, flash_clk_tick_o, mem_wait_o, stop_detect_nmi_o;
    logic [DIV_W-1:0] core_div_o, flash_div_o, periph_gen_div_o, periph_conv_div_o;
    logic tick_run = 1'b0;
    logic [7:0] w, r;
    logic [5:0] en;
    logic wd_before;
    int bad_count = 0;
    int checks = 0;
    int cycles = 0;
    int seed = 32'hde39584a;
    int g;
    cssd_clock_control #(.STOP_CYC(STOP_N)) cssd_clock_control_i (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o),
        .main_osc_tick_i(main_osc_tick_i), .main_osc_en_o(main_osc_en_o), .sub_osc_en_o(sub_osc_en_o),
        .fast_osc_en_o(fast_osc_en_o), .slow_osc_en_o(slow_osc_en_o), .watchdog_osc_en_o(watchdog_osc_en_o),
        .pll_en_o(pll_en_o), .sys_clk_source_o(sys_clk_source_o), .pll_free_run_o(pll_free_run_o),
        .core_div_o(core_div_o), .flash_div_o(flash_div_o), .periph_gen_div_o(periph_gen_div_o),
        .periph_conv_div_o(periph_conv_div_o), .flash_clk_tick_o(flash_clk_tick_o), .mem_wait_o(mem_wait_o),
        .stop_detect_nmi_o(stop_detect_nmi_o));
    assign en = {pll_en_o, watchdog_osc_en_o, slow_osc_en_o, fast_osc_en_o, sub_osc_en_o, main_osc_en_o};
    initial begin
        forever #50 sys_clk_i = ~sys_clk_i;
    end
    // main oscillator stand-in: toggles while running, frozen when stopped
    always @(posedge sys_clk_i) begin
        if (tick_run) main_osc_tick_i <= ~main_osc_tick_i;
    end
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == LIMIT) begin
            bad_count++;
            $display("mismatch at %0t: run did not finish in time", $time);
            final_report();
        end
    end
    // ==============================================
    // tasks
    function automatic logic [3:0] sat(input logic [3:0] v);
        return (v > DIV_MAX) ? DIV_MAX : v;
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        we_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge sys_clk_i);
        we_i <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge sys_clk_i);
        re_i <= 1'b1;
        addr_i <= a;
        @(posedge sys_clk_i);
        re_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask
    // waits a bounded time for the effective source to become want
    task automatic wait_src(input logic [2:0] want);
        int n;
        n = 0;
        while (sys_clk_source_o !== want && n < 10 * STOP_N) begin
            @(posedge sys_clk_i);
            #1;
            n++;
        end
    endtask
    // cycles from one flash tick to the next, bounded
    task automatic tick_gap(output int gap);
        int n;
        n = 0;
        do begin
            @(posedge sys_clk_i);
            #1;
            n++;
        end while (flash_clk_tick_o !== 1'b1 && n < 300);
        gap = n;
    endtask
    task automatic final_report();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ==============================================
    // main sequence
    initial begin
        repeat (2) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        #1;
        chk({2'h0, en}, 8'h08, "reset enables");
        chk({5'h0, sys_clk_source_o}, {5'h0, SRC_SLOW_INT}, "reset source");
        chk({core_div_o, flash_div_o}, 8'h00, "reset dividers");
        repeat (3 * STOP_N + 4) @(posedge sys_clk_i);
        rd(OFS_DET_STATUS, r);
        chk(r & 8'h01, 8'h00, "flag with detector off");
        chk({7'h0, stop_detect_nmi_o}, 8'h00, "nmi with detector off");
        $display("test reset done");
        for (int j = 0; j < 12; j++) begin
            w = $random(seed);
            wr(j % 6, w);
            rd(j % 6, r);
            chk(r & 8'h01, w & 8'h01, "osc control readback");
            chk({7'h0, en[j % 6]}, {7'h0, ~w[0]}, "osc enable");
        end
        $display("test oscillators done");
        for (int j = 0; j < 8; j++) begin
            w = (j == 0) ? 8'h66 : (j == 1) ? 8'h7F : (j == 2) ? 8'hF8 : $random(seed);
            wr(OFS_DIV_CORE_FLASH, w);
            chk({core_div_o, flash_div_o}, {sat(w[3:0]), sat(w[7:4])}, "core flash dividers");
            wr(OFS_DIV_PERIPH, ~w);
            chk({periph_gen_div_o, periph_conv_div_o}, {sat(~w[3:0]), sat(~w[7:4])}, "periph dividers");
        end
        for (int n = 0; n < 7; n++) begin
            wr(OFS_DIV_CORE_FLASH, {n[3:0], 4'h0});
            tick_gap(g);
            tick_gap(g);
            chk(g[7:0], 8'h01 << n, "flash tick spacing");
        end
        $display("test dividers done");
        for (int a = 13; a < 16; a++) begin
            wr(a[3:0], 8'hFF);
            rd(a[3:0], r);
            chk(r, 8'h00, "unmapped read");
        end
        $display("test unmapped done");
        wr(OFS_MAIN_OSC_CTL, 8'h00);
        tick_run = 1'b1;
        wr(OFS_NMI_EN, 8'h01);
        wr(OFS_SRC_SEL, {5'h0, SRC_MAIN});
        wr(OFS_DET_CTL, 8'h01);
        wait_src(SRC_MAIN);
        chk({5'h0, sys_clk_source_o}, {5'h0, SRC_MAIN}, "main selected");
        wd_before = watchdog_osc_en_o;
        tick_run = 1'b0;
        wait_src(SRC_SLOW_INT);
        chk({5'h0, sys_clk_source_o}, {5'h0, SRC_SLOW_INT}, "fallback to slow");
        rd(OFS_SRC_SEL, r);
        chk(r & 8'h07, {5'h0, SRC_MAIN}, "select field kept");
        rd(OFS_DET_STATUS, r);
        chk(r & 8'h01, 8'h01, "flag set");
        chk({7'h0, stop_detect_nmi_o}, 8'h01, "nmi raised");
        chk({7'h0, watchdog_osc_en_o}, {7'h0, wd_before}, "watchdog osc kept");
        chk({7'h0, mem_wait_o}, 8'h00, "no memory wait");
        tick_run = 1'b1;
        wr(OFS_DET_STATUS, 8'h00);
        rd(OFS_DET_STATUS, r);
        chk(r & 8'h01, 8'h01, "clear refused while main selected");
        chk({5'h0, sys_clk_source_o}, {5'h0, SRC_SLOW_INT}, "fallback held");
        wr(OFS_SRC_SEL, {5'h0, SRC_SLOW_INT});
        wr(OFS_DET_STATUS, 8'h00);
        rd(OFS_DET_STATUS, r);
        chk(r & 8'h01, 8'h00, "flag cleared");
        chk({7'h0, stop_detect_nmi_o}, 8'h00, "nmi dropped");
        wr(OFS_SRC_SEL, {5'h0, SRC_MAIN});
        wait_src(SRC_MAIN);
        chk({5'h0, sys_clk_source_o}, {5'h0, SRC_MAIN}, "main reselected");
        $display("test main fallback done");
        wr(OFS_NMI_EN, 8'h00);
        wr(OFS_PLL_CTL, 8'h00);
        wr(OFS_SRC_SEL, {5'h0, SRC_PLL});
        tick_run = 1'b0;
        repeat (3 * STOP_N + 4) @(posedge sys_clk_i);
        #1;
        chk({5'h0, sys_clk_source_o}, {5'h0, SRC_PLL}, "pll source kept");
        chk({7'h0, pll_free_run_o}, 8'h01, "pll runs free");
        chk({7'h0, stop_detect_nmi_o}, 8'h00, "nmi masked");
        rd(OFS_CLK_STATUS, r);
        chk(r & 8'h0F, {4'h1, 1'b0, SRC_PLL} & 8'h0F | 8'h08, "clock status");
        wr(OFS_DET_CTL, 8'h00);
        wr(OFS_MAIN_OSC_CTL, 8'h01);
        chk({7'h0, main_osc_en_o}, 8'h00, "main stopped after detector off");
        $display("test pll fallback done");
        for (int k = 0; k < 2; k++) begin
            w = (k == 0) ? {5'h0, SRC_FAST_INT} : {5'h0, SRC_SUB};
            wr(OFS_SRC_SEL, w);
            wait_src(w[2:0]);
            chk({5'h0, sys_clk_source_o}, w, "other source selected");
        end
        // program pass: core undivided, flash at half rate, 5 MHz
        wr(OFS_DIV_CORE_FLASH, 8'h10);
        chk({core_div_o, flash_div_o}, 8'h01, "flash program setting");
        // flash idle: largest ratio saves power
        wr(OFS_DIV_CORE_FLASH, 8'h60);
        chk({4'h0, flash_div_o}, {4'h0, DIV_MAX}, "idle flash divider");
        wr(OFS_PLL_CTL, 8'h01);
        chk({7'h0, pll_en_o}, 8'h00, "pll powered off");
        $display("test power settings done");
        final_report();
    end
endmodule
`default_nettype wire
